// File: hw/lcts_top.sv
// Link controller timeslot selection and custom transmit pulse configuration
// What this block does
// - Selector bit 7 high attaches second link controller; low detaches it.
// - Selector bit 7 high attaches third link controller; low detaches it.
// - Bits 4-0 of each selector hold the timeslot channel number.
// - Channel 0 is the first timeslot; only 0 to 23 are usable.
// - In the chosen slot, transmit data comes from the controller, not serial input.
// - Receive slot data goes to the controller from line, before elastic buffer.
// - First pulse register bits 6-0 set drive level in first mark phase.
// - Second pulse register bits 6-0 set drive level in second mark phase.
// - Third pulse register bits 6-0 set drive level in third mark phase.
// - Larger magnitude in bits 5-0 gives larger transmitted amplitude.
// - Pulse levels drive the line only while the enable bit 3 is high; here the custom_pulse_enable pin gates them instead.
// - Top bit is sign, 1 positive; low six bits magnitude, 0.1 V steps.
module lcts_top
    import lcts_pkg::*;
#(
    parameter int SLOTS = 24
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hostWr,
    input wire logic hostRd,
    input wire logic [4:0] hostAddr,
    input wire logic [7:0] hostWdata,
    output logic [7:0] hostRdata_q,
    input wire logic custom_pulse_enable,
    input wire logic bitStrobe,
    input wire logic frameStart,
    input wire logic serial_data_in,
    output logic txLineBit_q,
    input wire logic rxLineBit,
    input wire logic ctrlSecondTxBit,
    input wire logic ctrlThirdTxBit,
    output logic ctrlSecondTxReq_q,
    output logic ctrlThirdTxReq_q,
    output logic rxSlotValid_q,
    input wire logic rxSlotReady,
    output logic [1:0] rxSlotData_q,
    output logic [1:0] rxSlotDest_q,
    input wire logic markPhaseValid,
    input wire logic [1:0] markPhase,
    output logic [LCTS_LEVEL_W-1:0] driveLevel_q,
    output logic driveCustom_q
);
    lcts_sel_s secondSel;
    lcts_sel_s thirdSel;
    logic [4:0] wrHit;
    logic [7:0] secondRaw_q;
    logic [7:0] thirdRaw_q;
    logic [7:0] phaseOne_q;
    logic [7:0] phaseTwo_q;
    logic [7:0] phaseThree_q;
    logic [4:0] slot_q;
    logic [2:0] bitCnt_q;
    logic [4:0] pinsSync;
    logic strobeS;
    logic frameS;
    logic txInS;
    logic rxInS;
    logic cplS;
    logic inSecond;
    logic inThird;
    logic bufInValid;
    logic [3:0] bufInData;
    logic bufOutValid;
    logic [3:0] bufOutData;
    logic bufPop;
    lcts_phase_e phase;

    // Slot match for an attached controller
    function automatic logic slotHit(input lcts_sel_s sel, input logic [4:0] slot);
        slotHit = sel.enable && (sel.channel == slot) && (sel.channel <= LCTS_LAST_SLOT);
    endfunction

    // Sign and magnitude of a stored pulse word
    function automatic lcts_level_s levelOf(input logic [7:0] raw);
        levelOf = lcts_level_s'(raw[LCTS_LEVEL_W-1:0]);
    endfunction

    lcts_sync #(
        .WIDTH(5)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .din({bitStrobe, frameStart, serial_data_in, rxLineBit, custom_pulse_enable}),
        .dout(pinsSync)
    );

    assign {strobeS, frameS, txInS, rxInS, cplS} = pinsSync;

    // Host address to one-hot register select, zero when unmapped
    function automatic logic [4:0] regHit(input logic [4:0] addr);
        case (addr)
            LCTS_ADDR_SECOND_SEL: regHit = 5'h01;
            LCTS_ADDR_THIRD_SEL: regHit = 5'h02;
            LCTS_ADDR_PHASE_ONE: regHit = 5'h04;
            LCTS_ADDR_PHASE_TWO: regHit = 5'h08;
            LCTS_ADDR_PHASE_THREE: regHit = 5'h10;
            default: regHit = 5'h00;
        endcase
    endfunction

    assign wrHit = hostWr ? regHit(hostAddr) : 5'h00;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            secondRaw_q <= LCTS_REG_RESET;
        end else if (wrHit[0]) begin
            secondRaw_q <= hostWdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            thirdRaw_q <= LCTS_REG_RESET;
        end else if (wrHit[1]) begin
            thirdRaw_q <= hostWdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phaseOne_q <= LCTS_REG_RESET;
        end else if (wrHit[2]) begin
            phaseOne_q <= hostWdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phaseTwo_q <= LCTS_REG_RESET;
        end else if (wrHit[3]) begin
            phaseTwo_q <= hostWdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phaseThree_q <= LCTS_REG_RESET;
        end else if (wrHit[4]) begin
            phaseThree_q <= hostWdata;
        end
    end

    assign secondSel.enable = secondRaw_q[LCTS_SEL_EN_BIT];
    assign secondSel.channel = secondRaw_q[LCTS_CH_LSB +: LCTS_CH_W];
    assign thirdSel.enable = thirdRaw_q[LCTS_SEL_EN_BIT];
    assign thirdSel.channel = thirdRaw_q[LCTS_CH_LSB +: LCTS_CH_W];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hostRdata_q <= 8'h00;
        end else if (hostRd) begin
            case (hostAddr)
                LCTS_ADDR_SECOND_SEL: hostRdata_q <= secondRaw_q;
                LCTS_ADDR_THIRD_SEL: hostRdata_q <= thirdRaw_q;
                LCTS_ADDR_PHASE_ONE: hostRdata_q <= phaseOne_q;
                LCTS_ADDR_PHASE_TWO: hostRdata_q <= phaseTwo_q;
                LCTS_ADDR_PHASE_THREE: hostRdata_q <= phaseThree_q;
                default: hostRdata_q <= 8'h00;
            endcase
        end
    end

    // timeslot counter, zero at frame start
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slot_q <= 5'h00;
            bitCnt_q <= 3'h0;
        end else if (frameS) begin
            // Strobe with frame start is bit 0 of slot 0
            slot_q <= 5'h00;
            bitCnt_q <= strobeS ? 3'h1 : 3'h0;
        end else if (strobeS) begin
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'(LCTS_SLOT_BITS - 1)) begin
                slot_q <= (slot_q == 5'(SLOTS - 1)) ? 5'h00 : slot_q + 5'h01;
            end
        end
    end

    assign inSecond = slotHit(secondSel, slot_q);
    assign inThird = slotHit(thirdSel, slot_q);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            txLineBit_q <= 1'b0;
        end else if (strobeS) begin
            if (inSecond) begin
                txLineBit_q <= ctrlSecondTxBit;
            end else if (inThird) begin
                txLineBit_q <= ctrlThirdTxBit;
            end else begin
                txLineBit_q <= txInS;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrlSecondTxReq_q <= 1'b0;
        end else begin
            ctrlSecondTxReq_q <= strobeS && inSecond;
        end
    end

    // third controller yields a shared slot
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrlThirdTxReq_q <= 1'b0;
        end else begin
            ctrlThirdTxReq_q <= strobeS && inThird && !inSecond;
        end
    end

    // receive tap ahead of the elastic buffer
    assign bufInValid = strobeS && (inSecond || inThird);
    assign bufInData = {inThird, inSecond, rxInS, rxInS};
    assign bufPop = bufOutValid && (!rxSlotValid_q || rxSlotReady);

    lcts_skid #(
        .WIDTH(4)
    ) u_skid (
        .core_clk(core_clk),
        .nrst(nrst),
        .inValid(bufInValid),
        .inReady(),
        .inData(bufInData),
        .outValid(bufOutValid),
        .outReady(!rxSlotValid_q || rxSlotReady),
        .outData(bufOutData)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rxSlotValid_q <= 1'b0;
            rxSlotData_q <= 2'b00;
            rxSlotDest_q <= 2'b00;
        end else if (bufPop) begin
            rxSlotValid_q <= 1'b1;
            rxSlotData_q <= bufOutData[1:0];
            rxSlotDest_q <= bufOutData[3:2];
        end else if (rxSlotReady) begin
            rxSlotValid_q <= 1'b0;
        end
    end

    always_comb begin
        case (markPhase)
            2'd0: phase = PHASE_ONE;
            2'd1: phase = PHASE_TWO;
            2'd2: phase = PHASE_THREE;
            default: phase = PHASE_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            driveLevel_q <= '0;
            driveCustom_q <= 1'b0;
        end else if (!cplS || !markPhaseValid) begin
            driveLevel_q <= '0;
            driveCustom_q <= 1'b0;
        end else begin
            // level passed as sign and magnitude
            case (phase)
                PHASE_ONE: begin
                    driveLevel_q <= levelOf(phaseOne_q);
                    driveCustom_q <= 1'b1;
                end
                PHASE_TWO: begin
                    driveLevel_q <= levelOf(phaseTwo_q);
                    driveCustom_q <= 1'b1;
                end
                PHASE_THREE: begin
                    driveLevel_q <= levelOf(phaseThree_q);
                    driveCustom_q <= 1'b1;
                end
                default: begin
                    driveLevel_q <= '0;
                    driveCustom_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: hw/lcts_pkg.sv
// Package of constants and carrier types for the timeslot and pulse configuration block
package lcts_pkg;
    localparam logic [4:0] LCTS_ADDR_SECOND_SEL = 5'h19;
    localparam logic [4:0] LCTS_ADDR_THIRD_SEL = 5'h1A;
    localparam logic [4:0] LCTS_ADDR_PHASE_ONE = 5'h1B;
    localparam logic [4:0] LCTS_ADDR_PHASE_TWO = 5'h1C;
    localparam logic [4:0] LCTS_ADDR_PHASE_THREE = 5'h1D;
    localparam int LCTS_SEL_EN_BIT = 7;
    localparam int LCTS_CH_LSB = 0;
    localparam int LCTS_CH_W = 5;
    localparam int LCTS_LEVEL_W = 7;
    localparam int LCTS_SIGN_BIT = 6;
    localparam int LCTS_MAG_W = 6;
    localparam int LCTS_CPL_BIT = 3;
    localparam logic [4:0] LCTS_LAST_SLOT = 5'h17;
    localparam logic [7:0] LCTS_REG_RESET = 8'h00;
    localparam int LCTS_SLOT_BITS = 8;
    localparam int LCTS_SYNC_STAGES = 2;

    typedef struct packed {
        logic enable;
        logic [LCTS_CH_W-1:0] channel;
    } lcts_sel_s;

    typedef struct packed {
        logic sign;
        logic [LCTS_MAG_W-1:0] magnitude;
    } lcts_level_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } lcts_host_s;

    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_ONE,
        PHASE_TWO,
        PHASE_THREE
    } lcts_phase_e;
endpackage

// File: hw/lcts_sync.sv
// Two-stage synchroniser for pin inputs
module lcts_sync
    import lcts_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// File: hw/lcts_skid.sv
// Two-entry buffer with valid and ready on both sides
module lcts_skid
    import lcts_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_q [2];
    logic wrPtr_q;
    logic rdPtr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign inReady = (count_q != 2'd2);
    assign outValid = (count_q != 2'd0);
    assign outData = mem_q[rdPtr_q];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'd0;
        end else begin
            if (push) begin
                mem_q[wrPtr_q] <= inData;
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= ~rdPtr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: verification/lcts_checker.sv
// Port assertions for the timeslot and pulse configuration block
module lcts_checker
    import lcts_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hostWr,
    input wire logic hostRd,
    input wire logic [4:0] hostAddr,
    input wire logic [7:0] hostWdata,
    input wire logic [7:0] hostRdata_q,
    input wire logic custom_pulse_enable,
    input wire logic bitStrobe,
    input wire logic txLineBit_q,
    input wire logic ctrlSecondTxReq_q,
    input wire logic ctrlThirdTxReq_q,
    input wire logic rxSlotValid_q,
    input wire logic rxSlotReady,
    input wire logic [1:0] rxSlotData_q,
    input wire logic [1:0] rxSlotDest_q,
    input wire logic [LCTS_LEVEL_W-1:0] driveLevel_q,
    input wire logic driveCustom_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    logic mapped;
    assign mapped = hostAddr >= LCTS_ADDR_SECOND_SEL && hostAddr <= LCTS_ADDR_PHASE_THREE;
    sequence s_wr_rd;
        hostWr && mapped ##1 !hostWr && !hostRd ##1 hostRd && hostAddr == $past(hostAddr, 2);
    endsequence
    sequence s_quiet;
        !bitStrobe [*6];
    endsequence
    AST_RD_UNMAPPED: assert property (
        hostRd && !mapped |=> hostRdata_q == 8'h00) else $error("unmapped read not zero");
    AST_RD_BACK: assert property (
        s_wr_rd |=> hostRdata_q == $past(hostWdata, 3)) else $error("readback differs");
    AST_DRIVE_OFF: assert property (
        !custom_pulse_enable [*4] |-> driveLevel_q == '0 && !driveCustom_q)
        else $error("custom level while disabled");
    AST_RX_HOLD: assert property (
        rxSlotValid_q && !rxSlotReady |=> rxSlotValid_q && $stable(rxSlotData_q)
        && $stable(rxSlotDest_q)) else $error("rx word lost in stall");
    AST_RX_FORM: assert property (
        rxSlotValid_q |-> rxSlotData_q[0] == rxSlotData_q[1] && rxSlotDest_q != 2'b00)
        else $error("rx word malformed");
    AST_REQ_ONE: assert property (
        !(ctrlSecondTxReq_q && ctrlThirdTxReq_q)) else $error("two controllers in one bit");
    AST_TX_QUIET: assert property (
        s_quiet |-> $stable(txLineBit_q)) else $error("tx bit moved without strobe");
    AST_REQ_QUIET: assert property (
        s_quiet |-> !ctrlSecondTxReq_q && !ctrlThirdTxReq_q) else $error("request without strobe");
endmodule

bind lcts_top lcts_checker u_chk (.*);

// File: verification/lcts_host_model.sv
// Host processor model driving the register port
module lcts_host_model
    import lcts_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] hostRdata_q,
    output logic hostWr,
    output logic hostRd,
    output logic [4:0] hostAddr,
    output logic [7:0] hostWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hostWr = 1'b0;
        hostRd = 1'b0;
        hostAddr = 5'h00;
        hostWdata = 8'h00;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        hostWdata = (a < LCTS_ADDR_PHASE_ONE) ? (d & 8'h9F) : (d & 8'h7F);
        hostAddr = a;
        hostWr = 1'b1;
        @(negedge core_clk);
        hostWr = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        hostAddr = a;
        hostRd = 1'b1;
        @(negedge core_clk);
        hostRd = 1'b0;
        @(negedge core_clk);
        d = hostRdata_q;
    endtask
endmodule

// File: verification/lcts_top_tb.sv
// Self-checking bench for the timeslot and pulse configuration block
module lcts_top_tb
    import lcts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hostWr, hostRd, custom_pulse_enable, bitStrobe, frameStart, serial_data_in;
    logic txLineBit_q, rxLineBit, ctrlSecondTxBit, ctrlThirdTxBit, ctrlSecondTxReq_q;
    logic ctrlThirdTxReq_q, rxSlotValid_q, rxSlotReady, driveCustom_q, markPhaseValid;
    logic [4:0] hostAddr;
    logic [7:0] hostWdata, hostRdata_q;
    logic [1:0] rxSlotData_q, rxSlotDest_q, markPhase;
    logic [LCTS_LEVEL_W-1:0] driveLevel_q;
    int fails = 0;
    int num_checks = 0;
    int w2 = 0;
    int w3 = 0;
    int r2 = 0;
    int r3 = 0;
    lcts_top dut (.*);
    lcts_host_model u_host (.*);
    always #2 core_clk = ~core_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (nrst && rxSlotValid_q && rxSlotReady) begin
            w2 = w2 + int'(rxSlotDest_q[0]);
            w3 = w3 + int'(rxSlotDest_q[1]);
            check({6'h00, rxSlotData_q}, {6'h00, rxLineBit, rxLineBit});
        end
    end
    always @(posedge core_clk) begin
        r2 = r2 + int'(ctrlSecondTxReq_q);
        r3 = r3 + int'(ctrlThirdTxReq_q);
    end
    task automatic t_regs();
        logic [7:0] v;
        for (int i = 0; i < 5; i++) begin
            u_host.rd(LCTS_ADDR_SECOND_SEL + 5'(i), v);
            check(v, LCTS_REG_RESET);
        end
        u_host.wr(5'h1E, 8'hFF);
        u_host.rd(5'h1E, v);
        check(v, 8'h00);
        for (int i = 0; i < 5; i++) begin
            u_host.wr(LCTS_ADDR_SECOND_SEL + 5'(i), 8'h55 + 8'(i));
        end
        for (int i = 4; i >= 0; i--) begin
            u_host.rd(LCTS_ADDR_SECOND_SEL + 5'(i), v);
            check(v, (i < 2) ? ((8'h55 + 8'(i)) & 8'h9F) : (8'h55 + 8'(i)));
        end
        $display("t_regs done");
    endtask
    task automatic t_drive();
        custom_pulse_enable = 1'b1;
        markPhaseValid = 1'b1;
        repeat (5) @(negedge core_clk);
        for (int p = 0; p < 3; p++) begin
            markPhase = 2'(p);
            repeat (3) @(negedge core_clk);
            check({1'b0, driveLevel_q}, 8'h57 + 8'(p));
            check({7'h00, driveCustom_q}, 8'h01);
        end
        custom_pulse_enable = 1'b0;
        markPhase = 2'h0;
        repeat (6) @(negedge core_clk);
        check({1'b0, driveLevel_q}, 8'h00);
        markPhaseValid = 1'b0;
        $display("t_drive done");
    endtask
    task automatic t_frame(input logic en);
        logic expTx;
        u_host.wr(LCTS_ADDR_SECOND_SEL, {en, 7'h00});
        u_host.wr(LCTS_ADDR_THIRD_SEL, {en, 7'h17});
        w2 = 0;
        w3 = 0;
        r2 = 0;
        r3 = 0;
        for (int i = 0; i < 192; i++) begin
            serial_data_in = i[0];
            rxLineBit = i[1];
            frameStart = (i == 0);
            bitStrobe = 1'b1;
            rxSlotReady = 1'b0;
            @(negedge core_clk);
            bitStrobe = 1'b0;
            frameStart = 1'b0;
            // Receiver stalls while the slot word waits
            repeat (4) @(negedge core_clk);
            rxSlotReady = 1'b1;
            repeat (2) @(negedge core_clk);
            expTx = (en && i < 8) ? 1'b1 : ((en && i >= 184) ? 1'b0 : i[0]);
            check({7'h00, txLineBit_q}, {7'h00, expTx});
        end
        repeat (10) @(negedge core_clk);
        check(8'(w2), en ? 8'h08 : 8'h00);
        check(8'(w3), en ? 8'h08 : 8'h00);
        check(8'(r2), en ? 8'h08 : 8'h00);
        check(8'(r3), en ? 8'h08 : 8'h00);
        $display("t_frame done");
    endtask
    initial begin
        custom_pulse_enable = 1'b0;
        bitStrobe = 1'b0;
        frameStart = 1'b0;
        serial_data_in = 1'b0;
        rxLineBit = 1'b1;
        ctrlSecondTxBit = 1'b1;
        ctrlThirdTxBit = 1'b0;
        rxSlotReady = 1'b1;
        markPhaseValid = 1'b0;
        markPhase = 2'h3;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        t_regs();
        t_drive();
        t_frame(1'b1);
        t_frame(1'b0);
        end_sim();
    end
endmodule
